// ==== pkg/osc_params.svh ====
// Purpose: constants for the internal oscillator control block
// Assumes: register index = printed offset, byte address = 4 * index
// Notes:   definitions only
`ifndef OSC_PARAMS_SVH
`define OSC_PARAMS_SVH

// register indices
`define IDX_CUR_SRC      10'h20e
`define IDX_SEC_PWR      10'h20f
`define IDX_READY        10'h210
`define IDX_FORCE        10'h211
`define IDX_TRIM         10'h212
`define IDX_FREQ         10'h213
`define IDX_ACT          10'h214

// byte address split: index above, byte offset below
`define IDX_LSB          2
`define IDX_MSB          11

// field positions
`define POS_FAST         6
`define POS_MEDIUM       5
`define POS_SLOW         4
`define POS_SECONDARY    3
`define POS_CONVERTER    2
`define POS_FIXED        1
`define POS_SEC_PWR      6
`define POS_CUR_SRC_LO   4
`define POS_TUNE_EN      7
`define POS_TUNE_HOLD    6
`define POS_TUNE_LOCK    3
`define POS_TUNE_RANGE   1

// masks and reset values
`define FORCE_MASK       8'h7c
`define RST_FORCE        8'h00
`define RST_SEC_PWR      1'b1
`define RST_TRIM         6'h00
`define RST_FREQ         3'h0
`define FREQ_LAST_LEGAL  3'h5

`endif

// ==== pkg/osc_pkg.sv ====
// Purpose: types for the internal oscillator control block
// Assumes: nothing
// Notes:   constants live in osc_params.svh
package osc_pkg;
	typedef enum logic [2:0] {
		FREQ_1MHZ  = 3'h0,
		FREQ_2MHZ  = 3'h1,
		FREQ_4MHZ  = 3'h2,
		FREQ_8MHZ  = 3'h3,
		FREQ_16MHZ = 3'h4,
		FREQ_32MHZ = 3'h5
	} freq_e;
	typedef logic [5:0] trim_t;
	typedef logic [6:1] osc_vec_t;
endpackage

// ==== core/internal_oscillator_control.sv ====
// Purpose: register file and run/ready logic for the internal oscillators
// Assumes: Avalon-MM slave, byte addressed, one wait state per access
// Notes:   oscillator vectors are indexed by status bit position 6..1
`timescale 1ns/1ps
`include "osc_params.svh"

// Overview of operation
// - the 3-bit frequency select picks 1,2,4,8,16 or 32 MHz, codes 110/111 are reserved.
// - status bit 6 reads 1 only while the fast oscillator runs and is ready.
// - status bit 5 reads 1 only while the medium oscillator is ready.
// - status bit 4 reads 1 only while the slow oscillator is ready.
// - status bit 3 reads 1 only while the secondary crystal oscillator is ready.
// - status bit 2 reads 1 only while the converter RC oscillator is ready.
// - status bit 1 reads 1 only while the fixed oscillator is ready.
// - enable bit 6 forces the fast oscillator on at the selected frequency, else peripherals may.
// - enable bit 5 forces the medium oscillator on, else peripherals may start it.
// - enable bit 4 forces the slow oscillator on, else peripherals may start it.
// - enable bit 3 forces the secondary oscillator on in the chosen power mode.
// - enable bit 2 forces the converter oscillator on; all enable bits are RW, reset 0.
// - the secondary power bit selects high power at 1, low power at 0, and resets to 1.
// - the signed 6-bit trim moves the fast oscillator around its centre, default 0.
// - a read-only 3-bit field reports the source currently clocking the device.
module internal_oscillator_control #(
	parameter int ADDR_W = 12
) (
	// clock and reset
	input  wire logic                CLK_SYS,
	input  wire logic                RST,
	// avalon-mm slave
	input  wire logic [ADDR_W-1:0]   AVS_ADDRESS,
	input  wire logic                AVS_READ,
	input  wire logic                AVS_WRITE,
	input  wire logic [31:0]         AVS_WRITEDATA,
	input  wire logic [3:0]          AVS_BYTEENABLE,
	output logic      [31:0]         AVS_READDATA,
	output logic                     AVS_WAITREQUEST,
	// oscillator side
	input  wire logic [6:1]          OSC_PERIPH_REQ,
	input  wire logic [6:1]          OSC_VALID,
	output logic      [6:1]          OSC_RUN,
	input  wire logic [2:0]          CURRENT_SOURCE_CODE,
	input  wire logic                AUTO_TUNE_LOCKED,
	input  wire logic                AUTO_TUNE_OUT_OF_RANGE,
	// oscillator settings
	output logic      [2:0]          FAST_OSC_FREQ_SELECT,
	output logic      [5:0]          FAST_OSC_TRIM_VALUE,
	output logic                     SECONDARY_POWER_SELECT,
	output logic                     AUTO_TUNE_ENABLE,
	output logic                     AUTO_TUNE_UPDATE_HOLD
);

	// bus handshake state
	logic                ack_reg;
	logic                ack_next;
	logic [31:0]         rdata_reg;
	logic [31:0]         rdata_next;

	// software registers
	logic [7:0]          force_reg;
	logic [7:0]          force_next;
	logic                sec_pwr_reg;
	logic                sec_pwr_next;
	osc_pkg::trim_t      trim_reg;
	osc_pkg::trim_t      trim_next;
	osc_pkg::freq_e      freq_reg;
	osc_pkg::freq_e      freq_next;
	logic                tune_en_reg;
	logic                tune_en_next;
	logic                tune_hold_reg;
	logic                tune_hold_next;

	// oscillator state
	osc_pkg::osc_vec_t   valid_meta_reg;
	osc_pkg::osc_vec_t   valid_sync_reg;
	osc_pkg::osc_vec_t   run_reg;
	osc_pkg::osc_vec_t   run_next;
	osc_pkg::osc_vec_t   ready_reg;
	osc_pkg::osc_vec_t   ready_next;

	// decode
	logic                req;
	logic                wr_go;
	logic                lane0;
	logic                addr_ok;
	logic [9:0]          idx;
	logic [7:0]          rd_byte;
	osc_pkg::osc_vec_t   force_vec;
	logic                upper_ok;
	logic                freq_ok;
	logic                trim_sw_ok;

	// individual status bits
	logic                fast_rdy;
	logic                med_rdy;
	logic                slow_rdy;
	logic                sec_rdy;
	logic                conv_rdy;
	logic                fix_rdy;

	// bits above the map must be clear, else a wider bus aliases the registers
	if (ADDR_W > `IDX_MSB + 1) begin : g_upper
		assign upper_ok = (AVS_ADDRESS[ADDR_W-1:`IDX_MSB+1] == '0);
	end else begin : g_no_upper
		assign upper_ok = 1'b1;
	end

	assign req     = AVS_READ | AVS_WRITE;
	assign idx     = AVS_ADDRESS[`IDX_MSB:`IDX_LSB];
	assign addr_ok = (AVS_ADDRESS[`IDX_LSB-1:0] == '0) & upper_ok;
	assign lane0   = AVS_BYTEENABLE[0];
	// write lands on the edge where waitrequest is sampled low
	assign wr_go   = AVS_WRITE & ack_reg & addr_ok & lane0;
	// reserved codes are refused so the output never leaves the table
	assign freq_ok    = (AVS_WRITEDATA[2:0] <= `FREQ_LAST_LEGAL);
	// tuning engine or hold bit owns the trim; software writes drop
	assign trim_sw_ok = ~tune_en_reg & ~tune_hold_reg;

	assign fast_rdy = ready_reg[`POS_FAST];
	assign med_rdy  = ready_reg[`POS_MEDIUM];
	assign slow_rdy = ready_reg[`POS_SLOW];
	assign sec_rdy  = ready_reg[`POS_SECONDARY];
	assign conv_rdy = ready_reg[`POS_CONVERTER];
	assign fix_rdy  = ready_reg[`POS_FIXED];

	// one wait state: first cycle decodes, second cycle answers
	always_comb begin
		ack_next = req & ~ack_reg;
	end

	assign AVS_WAITREQUEST = req & ~ack_reg;
	assign AVS_READDATA    = rdata_reg;

	// read mux; unmapped addresses read zero
	always_comb begin
		rd_byte = 8'h00;
		if (addr_ok) begin
			unique case (idx)
				`IDX_CUR_SRC: begin
					rd_byte[`POS_CUR_SRC_LO +: 3] = CURRENT_SOURCE_CODE;
				end
				`IDX_SEC_PWR: begin
					rd_byte[`POS_SEC_PWR] = sec_pwr_reg;
				end
				`IDX_READY: begin
					// no write path reaches these bits, so they stay read-only
					rd_byte[`POS_FAST]      = fast_rdy;
					rd_byte[`POS_MEDIUM]    = med_rdy;
					rd_byte[`POS_SLOW]      = slow_rdy;
					rd_byte[`POS_SECONDARY] = sec_rdy;
					rd_byte[`POS_CONVERTER] = conv_rdy;
					rd_byte[`POS_FIXED]     = fix_rdy;
				end
				`IDX_FORCE: begin
					rd_byte = force_reg;
				end
				`IDX_TRIM: begin
					rd_byte[5:0] = trim_reg;
				end
				`IDX_FREQ: begin
					rd_byte[2:0] = freq_reg;
				end
				`IDX_ACT: begin
					rd_byte[`POS_TUNE_EN]    = tune_en_reg;
					rd_byte[`POS_TUNE_HOLD]  = tune_hold_reg;
					rd_byte[`POS_TUNE_LOCK]  = AUTO_TUNE_LOCKED;
					rd_byte[`POS_TUNE_RANGE] = AUTO_TUNE_OUT_OF_RANGE;
				end
				default: begin
					rd_byte = 8'h00;
				end
			endcase
		end
	end

	always_comb begin
		rdata_next = rdata_reg;
		if (AVS_READ & ~ack_reg) begin
			rdata_next = {24'h00_0000, rd_byte};
		end
	end

	// register writes
	always_comb begin
		force_next     = force_reg;
		sec_pwr_next   = sec_pwr_reg;
		trim_next      = trim_reg;
		freq_next      = freq_reg;
		tune_en_next   = tune_en_reg;
		tune_hold_next = tune_hold_reg;
		if (wr_go) begin
			unique case (idx)
				`IDX_FORCE: begin
					force_next = AVS_WRITEDATA[7:0] & `FORCE_MASK;
				end
				`IDX_SEC_PWR: begin
					sec_pwr_next = AVS_WRITEDATA[`POS_SEC_PWR];
				end
				`IDX_TRIM: begin
					if (trim_sw_ok) begin
						trim_next = AVS_WRITEDATA[5:0];
					end
				end
				`IDX_FREQ: begin
					if (freq_ok) begin
						freq_next = osc_pkg::freq_e'(AVS_WRITEDATA[2:0]);
					end
				end
				`IDX_ACT: begin
					tune_en_next   = AVS_WRITEDATA[`POS_TUNE_EN];
					tune_hold_next = AVS_WRITEDATA[`POS_TUNE_HOLD];
				end
				default: begin
					force_next = force_reg;
				end
			endcase
		end
	end

	// run request and ready flags
	always_comb begin
		force_vec                 = '0;
		force_vec[`POS_FAST]      = force_reg[`POS_FAST];
		force_vec[`POS_MEDIUM]    = force_reg[`POS_MEDIUM];
		force_vec[`POS_SLOW]      = force_reg[`POS_SLOW];
		force_vec[`POS_SECONDARY] = force_reg[`POS_SECONDARY];
		force_vec[`POS_CONVERTER] = force_reg[`POS_CONVERTER];
		// fixed oscillator has no force bit; peripherals alone start it
		run_next   = force_vec | OSC_PERIPH_REQ;
		// ready needs the run request still present, so it drops with it
		ready_next = valid_sync_reg & run_reg & run_next;
	end

	// bus handshake registers
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			ack_reg   <= 1'b0;
			rdata_reg <= 32'h0000_0000;
		end else begin
			ack_reg   <= ack_next;
			rdata_reg <= rdata_next;
		end
	end

	// software registers
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			force_reg     <= `RST_FORCE;
			sec_pwr_reg   <= `RST_SEC_PWR;
			trim_reg      <= `RST_TRIM;
			freq_reg      <= osc_pkg::FREQ_1MHZ;
			tune_en_reg   <= 1'b0;
			tune_hold_reg <= 1'b0;
		end else begin
			force_reg     <= force_next;
			sec_pwr_reg   <= sec_pwr_next;
			trim_reg      <= trim_next;
			freq_reg      <= freq_next;
			tune_en_reg   <= tune_en_next;
			tune_hold_reg <= tune_hold_next;
		end
	end

	// valid comes from free-running analog cells, so synchronise
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			valid_meta_reg <= '0;
			valid_sync_reg <= '0;
		end else begin
			valid_meta_reg <= OSC_VALID;
			valid_sync_reg <= valid_meta_reg;
		end
	end

	// run requests and ready flags
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			run_reg   <= '0;
			ready_reg <= '0;
		end else begin
			run_reg   <= run_next;
			ready_reg <= ready_next;
		end
	end

	assign OSC_RUN                = run_reg;
	assign FAST_OSC_FREQ_SELECT   = freq_reg;
	assign FAST_OSC_TRIM_VALUE    = trim_reg;
	assign SECONDARY_POWER_SELECT = sec_pwr_reg;
	assign AUTO_TUNE_ENABLE       = tune_en_reg;
	assign AUTO_TUNE_UPDATE_HOLD  = tune_hold_reg;

endmodule

// ==== tb/osc_ctl_chk.sv ====
// Purpose: port assertions for the oscillator control block
// Assumes: master holds a request until waitrequest is low
// Notes:   bound from the bench top file
`timescale 1ns/1ps
`include "osc_params.svh"
module osc_ctl_chk #(
	parameter int ADDR_W = 12
) (
	// clock and bus
	input wire logic              CLK_SYS,
	input wire logic              RST,
	input wire logic [ADDR_W-1:0] AVS_ADDRESS,
	input wire logic              AVS_READ,
	input wire logic              AVS_WRITE,
	input wire logic [31:0]       AVS_WRITEDATA,
	input wire logic [3:0]        AVS_BYTEENABLE,
	input wire logic [31:0]       AVS_READDATA,
	input wire logic              AVS_WAITREQUEST,
	// oscillator side
	input wire logic [6:1]        OSC_PERIPH_REQ,
	input wire logic [6:1]        OSC_RUN,
	input wire logic [2:0]        FAST_OSC_FREQ_SELECT,
	input wire logic              SECONDARY_POWER_SELECT
);
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (RST);
	logic req;
	logic done;
	assign req = AVS_READ | AVS_WRITE;
	assign done = req & ~AVS_WAITREQUEST;
	property p_wait_first; !req ##1 req |-> AVS_WAITREQUEST; endproperty
	a_wait_first: assert property (p_wait_first) else $error("no wait state");
	property p_wait_one; req && AVS_WAITREQUEST |=> !AVS_WAITREQUEST; endproperty
	a_wait_one: assert property (p_wait_one) else $error("wait too long");
	property p_run;
		1'b1 |=> (OSC_RUN & $past(OSC_PERIPH_REQ)) == $past(OSC_PERIPH_REQ)
			&& OSC_RUN[1] == $past(OSC_PERIPH_REQ[1]);
	endproperty
	a_run: assert property (p_run) else $error("run lost request");
	// a ready bit may only show for an oscillator that was being run
	property p_ready;
		done && AVS_READ && AVS_ADDRESS == {`IDX_READY, 2'b00}
			|-> (AVS_READDATA & ~{25'h0, $past(OSC_RUN), 1'b0}) == 32'h0000_0000;
	endproperty
	a_ready: assert property (p_ready) else $error("ready without run");
	property p_freq_legal; FAST_OSC_FREQ_SELECT <= `FREQ_LAST_LEGAL; endproperty
	a_freq_legal: assert property (p_freq_legal) else $error("reserved freq");
	property p_freq_wr;
		done && AVS_WRITE && AVS_BYTEENABLE[0] && AVS_ADDRESS == {`IDX_FREQ, 2'b00}
			|=> FAST_OSC_FREQ_SELECT == ($past(AVS_WRITEDATA[2:0]) > `FREQ_LAST_LEGAL
			? $past(FAST_OSC_FREQ_SELECT) : $past(AVS_WRITEDATA[2:0]));
	endproperty
	a_freq_wr: assert property (p_freq_wr) else $error("freq write wrong");
	property p_hold;
		!(done && AVS_WRITE) |=> $stable({FAST_OSC_FREQ_SELECT, SECONDARY_POWER_SELECT});
	endproperty
	a_hold: assert property (p_hold) else $error("setting moved");
	property p_rst;
		$fell(RST) |-> FAST_OSC_FREQ_SELECT == 3'h0 && SECONDARY_POWER_SELECT
			&& OSC_RUN == 6'h00;
	endproperty
	a_rst: assert property (p_rst) else $error("bad reset value");
	c_ready: cover property (done && AVS_READ && AVS_READDATA[6:1] == 6'h3f);
	c_resv: cover property (done && AVS_WRITE && AVS_WRITEDATA[2:0] > 3'h5);
	c_run: cover property (OSC_RUN == 6'h3f);
endmodule

// ==== tb/tb_internal_oscillator_control.sv ====
// Purpose: self-checking bench for internal_oscillator_control
// Assumes: reads scored from a queue as each completes
// Notes:   one idle cycle between bus requests
`timescale 1ns/1ps
`include "osc_params.svh"
module tb_internal_oscillator_control;
	logic        clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, lock = 1'b0, oor = 1'b0;
	logic        wt, spwr, ten, thold;
	logic [11:0] addr = 12'h000;
	logic [31:0] wdata = 32'h0000_0000, rdata;
	logic [3:0]  be = 4'h0;
	logic [6:1]  req = 6'h00, valid = 6'h00, run;
	logic [2:0]  src = 3'h0, freq;
	logic [5:0]  trim;
	logic [7:0]  f, r, lk;
	logic [31:0] expq[$];
	int          err_total = 0, compares = 0, seed = 83;
	always #12.5 clk = ~clk;
	internal_oscillator_control dut (.CLK_SYS(clk), .RST(rst), .AVS_ADDRESS(addr),
		.AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be),
		.AVS_READDATA(rdata), .AVS_WAITREQUEST(wt), .OSC_PERIPH_REQ(req), .OSC_VALID(valid),
		.OSC_RUN(run), .CURRENT_SOURCE_CODE(src), .AUTO_TUNE_LOCKED(lock),
		.AUTO_TUNE_OUT_OF_RANGE(oor), .FAST_OSC_FREQ_SELECT(freq), .FAST_OSC_TRIM_VALUE(trim),
		.SECONDARY_POWER_SELECT(spwr), .AUTO_TUNE_ENABLE(ten), .AUTO_TUNE_UPDATE_HOLD(thold));
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [9:0] idx, input logic [7:0] d,
		input logic [3:0] b);
		addr <= {idx, 2'b00};
		wdata <= {24'h00_0000, d};
		be <= b;
		wr <= w;
		rd <= ~w;
		@(posedge clk);
		while (wt !== 1'b0)
			@(posedge clk);
		wr <= 1'b0;
		rd <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wrr(input logic [9:0] idx, input logic [7:0] d);
		bus(1'b1, idx, d, 4'hf);
	endtask
	task automatic rdr(input logic [9:0] idx, input logic [7:0] e);
		expq.push_back({24'h00_0000, e});
		bus(1'b0, idx, 8'h00, 4'hf);
	endtask
	task automatic end_of_test();
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	always @(posedge clk)
		if (rd === 1'b1 && wt === 1'b0)
			cmp(rdata, expq.pop_front());
	initial begin
		repeat (3000) @(posedge clk);
		err_total++;
		end_of_test();
	end
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		f = 8'($random(seed));
		lk = {4'h0, f[3], 1'b0, f[4], 1'b0};
		src <= f[2:0];
		lock <= f[3];
		oor <= f[4];
		wrr(`IDX_CUR_SRC, 8'hff);
		rdr(`IDX_CUR_SRC, {1'b0, f[2:0], 4'h0});
		rdr(`IDX_SEC_PWR, 8'h40);
		rdr(`IDX_READY, 8'h00);
		rdr(`IDX_FORCE, 8'h00);
		rdr(`IDX_TRIM, 8'h00);
		rdr(`IDX_ACT, lk);
		rdr(10'h208, 8'h00);
		$display("reset test done");
		r = 8'h00;
		for (int i = 0; i < 8; i++) begin
			wrr(`IDX_FREQ, 8'(i));
			if (i < 6)
				r = 8'(i);
			rdr(`IDX_FREQ, r);
			cmp({29'h0, freq}, {24'h00_0000, r});
		end
		$display("frequency test done");
		for (int i = 0; i < 4; i++) begin
			f = 8'($random(seed));
			r = 8'($random(seed));
			wrr(`IDX_FORCE, f);
			rdr(`IDX_FORCE, f & `FORCE_MASK);
			req <= r[6:1];
			repeat (2) @(posedge clk);
			cmp({26'h0, run}, {26'h0, f[6:1] & 6'h3e | r[6:1]});
		end
		$display("run test done");
		// every oscillator run, so ready tracks the synchronised valid lines
		wrr(`IDX_FORCE, 8'h7c);
		req <= 6'h01;
		for (int i = 0; i < 3; i++) begin
			r = (i == 0) ? 8'hff : 8'($random(seed));
			valid <= r[6:1];
			repeat (6) @(posedge clk);
			rdr(`IDX_READY, r & 8'h7e);
		end
		wrr(`IDX_READY, 8'h00);
		rdr(`IDX_READY, r & 8'h7e);
		wrr(`IDX_FORCE, 8'h00);
		req <= 6'h00;
		repeat (3) @(posedge clk);
		rdr(`IDX_READY, 8'h00);
		$display("ready test done");
		wrr(`IDX_SEC_PWR, 8'h00);
		rdr(`IDX_SEC_PWR, 8'h00);
		cmp({31'h0, spwr}, 32'h0000_0000);
		wrr(`IDX_TRIM, 8'h20);
		bus(1'b1, `IDX_TRIM, 8'h1f, 4'h0);
		rdr(`IDX_TRIM, 8'h20);
		for (int i = 0; i < 2; i++) begin
			f = (i == 0) ? 8'h80 : 8'h40;
			wrr(`IDX_ACT, f);
			rdr(`IDX_ACT, f | lk);
			cmp({30'h0, ten, thold}, {30'h0, f[7:6]});
			wrr(`IDX_TRIM, 8'h1f);
			rdr(`IDX_TRIM, 8'h20);
		end
		wrr(`IDX_ACT, 8'h00);
		wrr(`IDX_TRIM, 8'h1f);
		cmp({26'h0, trim}, 32'h0000_001f);
		$display("settings test done");
		// second reset in mid-run: changed settings must fall back
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rdr(`IDX_SEC_PWR, 8'h40);
		rdr(`IDX_FREQ, 8'h00);
		rdr(`IDX_TRIM, 8'h00);
		cmp({31'h0, spwr}, 32'h0000_0001);
		$display("reset rerun test done");
		end_of_test();
	end
endmodule
bind internal_oscillator_control osc_ctl_chk #(.ADDR_W(ADDR_W)) u_chk (.CLK_SYS(CLK_SYS),
	.RST(RST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
	.AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
	.AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
	.OSC_PERIPH_REQ(OSC_PERIPH_REQ), .OSC_RUN(OSC_RUN),
	.FAST_OSC_FREQ_SELECT(FAST_OSC_FREQ_SELECT),
	.SECONDARY_POWER_SELECT(SECONDARY_POWER_SELECT));
